// *** csi_slave_pkg.sv ***
// package: register offsets, field positions, reset values and states of the csi slave block
// assumes: one 20 MHz core clock; registers reached over a plain strobe port
package csi_slave_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_START   = 4'h0;
    localparam logic [3:0] OFF_STOP    = 4'h1;
    localparam logic [3:0] OFF_DIR     = 4'h2;
    localparam logic [3:0] OFF_PORT    = 4'h3;
    localparam logic [3:0] OFF_IRQ     = 4'h4;
    localparam logic [3:0] OFF_MASK    = 4'h5;
    localparam logic [3:0] OFF_MODE    = 4'h6;
    localparam logic [3:0] OFF_STATUS  = 4'h7;
    localparam logic [3:0] OFF_LEN     = 4'h8;
    localparam logic [3:0] OFF_TXDATA  = 4'h9;
    localparam logic [3:0] OFF_RXDATA  = 4'ha;
    localparam logic [3:0] OFF_TXPTR   = 4'hb;
    localparam logic [3:0] OFF_RXPTR   = 4'hc;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_CH0         = 0;
    localparam int BIT_DOUT_DIR    = 0;
    localparam int BIT_HS_PIN      = 4;
    localparam int BIT_SER_IRQ     = 3;
    localparam int BIT_MODE_IRQSRC = 0;
    localparam int BIT_MODE_LSB    = 1;
    localparam int BIT_MODE_TXE    = 2;
    localparam int BIT_MODE_RXE    = 3;
    localparam int BIT_ST_ENABLE   = 0;
    localparam int BIT_ST_ACTIVE   = 6;
    localparam int BIT_ST_BUFFULL  = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DIR  = 8'hff;
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_MODE = 8'h0c;
    localparam logic [7:0] RST_LEN  = 8'h01;

    localparam logic [7:0] LEN_MIN  = 8'h01;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        CH_STOP = 3'b001,
        CH_WAIT = 3'b010,
        CH_XFER = 3'b100
    } ch_state_t;

endpackage

// *** csi_shifter.sv ***
// one character shift engine: samples on rising sck, output bit follows the count that advances on rising sck
// assumes: sck and select are already synchronised and edge-detected by the caller
`timescale 1ns/1ps
module csi_shifter
    import csi_slave_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             arm_i,
    input  wire logic             sel_i,
    input  wire logic             rise_i,
    input  wire logic             fall_i,
    input  wire logic             lsb_first_i,
    input  wire logic             sdi_i,
    input  wire logic [7:0]       tx_i,
    output logic                  sdo_o,
    output logic [7:0]            rx_o,
    output logic                  done_o
);

    typedef struct packed {
        logic [7:0] sh;
        logic [7:0] rx;
        logic [2:0] cnt;
        logic       done;
    } sh_state_t;

    sh_state_t s_q;
    sh_state_t s_d;

    // bit index to present for a given count, honouring bit order
    function automatic logic [2:0] pos(input logic [2:0] c, input logic lsb);
        pos = lsb ? c : 3'(BIT_LAST - c);
    endfunction

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (arm_i) begin
            s_d.sh  = tx_i;
            s_d.cnt = '0;
        end else if (sel_i && rise_i) begin
            s_d.rx[pos(s_q.cnt, lsb_first_i)] = sdi_i;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == BIT_LAST) begin
                s_d.done = 1'b1;
            end
        end
        if (!sel_i) begin
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // output bit follows the count; it changes only after the rising sample edge
    assign sdo_o  = s_q.sh[pos(s_q.cnt, lsb_first_i)];
    assign rx_o   = s_q.rx;
    assign done_o = s_q.done;

endmodule

// *** csi_slave_start_and_handshake.sv ***
// top of the csi slave channel: registers, channel control, handshake and irq
// assumes: external master drives sck (mode: sample rising) and select low-active,
// and waits for the handshake line to read ready before each character
//
// How it works
// - writing one to start enables channel and enters communication wait; zero ignored
// - data out direction bit zero drives pin, one releases it
// - handshake level bit zero drives ready low, one drives busy high
// - handshake direction bit zero drives pin, one releases it
// - software loads ready level before turning handshake pin to output
// - request flag reads one while a transfer request is pending
// - mask zero lets request reach interrupt, one blocks it
// - continuous transfers take 1 to 255 characters, separate tx and rx pointers
// - bit order zero shifts msb first, one lsb first
// - irq source zero means transfer end, one means transmit buffer empty
// - active flag reads one while a transfer runs
// - writing one to stop clears enable and stops; zero ignored
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module csi_slave_start_and_handshake
    import csi_slave_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              sck_i,
    input  wire logic              sel_n_i,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe_o,
    output logic                   hs_o,
    output logic                   hs_oe_o,
    output logic                   irq_o
);

    typedef struct packed {
        ch_state_t  st;
        logic       enable;
        logic [7:0] dir;
        logic [7:0] port;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] mode;
        logic [7:0] len;
        logic [7:0] remain;
        logic [7:0] txbuf;
        logic       txfull;
        logic [7:0] rxbuf;
        logic [7:0] txptr;
        logic [7:0] rxptr;
        logic       arm;
        logic [7:0] rdata;
        logic [1:0] sck_s;
        logic [1:0] sel_s;
        logic [1:0] sdi_s;
        logic       sck_p;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic       sh_sdo;
    logic [7:0] sh_rx;
    logic       sh_done;
    logic       sck_rise;
    logic       sck_fall;
    logic       sel;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic s);
        hit = s && (a == off);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    // only the second stage of each synchroniser is read by logic
    assign sck_rise = s_q.sck_s[1] && !s_q.sck_p;
    assign sck_fall = !s_q.sck_s[1] && s_q.sck_p;
    assign sel      = !s_q.sel_s[1];

    csi_shifter u_shift (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .arm_i       (s_q.arm),
        .sel_i       (sel && s_q.st != CH_STOP),
        .rise_i      (sck_rise),
        .fall_i      (sck_fall),
        .lsb_first_i (s_q.mode[BIT_MODE_LSB]),
        .sdi_i       (s_q.sdi_s[1]),
        .tx_i        (s_q.txbuf),
        .sdo_o       (sh_sdo),
        .rx_o        (sh_rx),
        .done_o      (sh_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic ev;
        ev       = 1'b0;
        s_d      = s_q;
        s_d.arm  = 1'b0;
        s_d.sck_s = {s_q.sck_s[0], sck_i};
        s_d.sel_s = {s_q.sel_s[0], sel_n_i};
        s_d.sdi_s = {s_q.sdi_s[0], sdi_i};
        s_d.sck_p = s_q.sck_s[1];

        // register writes
        if (hit(addr_i, OFF_DIR, wr_i)) begin
            s_d.dir = wdata_i;
        end
        if (hit(addr_i, OFF_PORT, wr_i)) begin
            s_d.port = wdata_i;
        end
        if (hit(addr_i, OFF_MASK, wr_i)) begin
            s_d.mask = wdata_i;
        end
        if (hit(addr_i, OFF_MODE, wr_i)) begin
            s_d.mode = wdata_i;
        end
        if (hit(addr_i, OFF_LEN, wr_i) && wdata_i >= LEN_MIN) begin
            s_d.len = wdata_i;
        end
        if (hit(addr_i, OFF_TXDATA, wr_i)) begin
            s_d.txbuf  = wdata_i;
            s_d.txfull = 1'b1;
        end
        if (hit(addr_i, OFF_IRQ, wr_i)) begin
            s_d.flags = s_q.flags & ~wdata_i;
        end

        // channel sequencing
        unique case (s_q.st)
            CH_STOP: begin
                s_d.st = CH_STOP;
            end
            CH_WAIT: begin
                // hold off loading until software has signalled ready again
                if (sel && !s_q.port[BIT_HS_PIN]) begin
                    s_d.st  = CH_XFER;
                    s_d.arm = 1'b1;
                    s_d.txfull = 1'b0;
                    if (s_q.mode[BIT_MODE_IRQSRC]) begin
                        ev = 1'b1;
                    end
                end
            end
            CH_XFER: begin
                if (sh_done) begin
                    s_d.rxbuf = sh_rx;
                    if (s_q.mode[BIT_MODE_TXE]) begin
                        s_d.txptr = s_q.txptr + 8'h01;
                    end
                    if (s_q.mode[BIT_MODE_RXE]) begin
                        s_d.rxptr = s_q.rxptr + 8'h01;
                    end
                    s_d.remain = s_q.remain - 8'h01;
                    if (!s_q.mode[BIT_MODE_IRQSRC]) begin
                        ev = 1'b1;
                    end
                    // busy until software writes the ready level back to the port register
                    s_d.port[BIT_HS_PIN] = 1'b1;
                    s_d.st = (s_q.remain == LEN_MIN) ? CH_STOP : CH_WAIT;
                    if (s_q.remain == LEN_MIN) begin
                        s_d.enable = 1'b0;
                    end
                end else if (!sel) begin
                    s_d.st = CH_WAIT;
                end
            end
            default: s_d.st = CH_STOP;
        endcase

        // start wins over state advance; stop wins over start
        if (hit(addr_i, OFF_START, wr_i) && wdata_i[BIT_CH0]) begin
            s_d.enable = 1'b1;
            s_d.st     = CH_WAIT;
            s_d.remain = s_q.len;
            s_d.txptr  = '0;
            s_d.rxptr  = '0;
        end
        if (hit(addr_i, OFF_STOP, wr_i) && wdata_i[BIT_CH0]) begin
            s_d.enable = 1'b0;
            s_d.st     = CH_STOP;
        end

        // event set beats software clear
        if (ev) begin
            s_d.flags[BIT_SER_IRQ] = 1'b1;
        end

        // read data, valid the cycle after the strobe
        s_d.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                OFF_DIR:    s_d.rdata = s_q.dir;
                OFF_PORT:   s_d.rdata = s_q.port;
                OFF_IRQ:    s_d.rdata = s_q.flags;
                OFF_MASK:   s_d.rdata = s_q.mask;
                OFF_MODE:   s_d.rdata = s_q.mode;
                OFF_LEN:    s_d.rdata = s_q.len;
                OFF_RXDATA: s_d.rdata = s_q.rxbuf;
                OFF_TXPTR:  s_d.rdata = s_q.txptr;
                OFF_RXPTR:  s_d.rdata = s_q.rxptr;
                OFF_STATUS: begin
                    s_d.rdata[BIT_ST_ENABLE]  = s_q.enable;
                    s_d.rdata[BIT_ST_ACTIVE]  = (s_q.st == CH_XFER);
                    s_d.rdata[BIT_ST_BUFFULL] = s_q.txfull;
                end
                default:    s_d.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q       <= '0;
            s_q.st    <= CH_STOP;
            s_q.dir   <= RST_DIR;
            s_q.port  <= RST_PORT;
            s_q.mask  <= RST_MASK;
            s_q.mode  <= RST_MODE;
            s_q.len   <= RST_LEN;
            // idle-high sck: matching reset keeps a false edge out after release
            s_q.sck_s <= 2'h3;
            s_q.sck_p <= 1'b1;
            s_q.sel_s <= 2'h3;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata_o  = s_q.rdata;
    assign sdo_o    = sh_sdo;
    assign sdo_oe_o = !s_q.dir[BIT_DOUT_DIR];
    assign hs_o     = s_q.port[BIT_HS_PIN];
    assign hs_oe_o  = !s_q.dir[BIT_HS_PIN];
    assign irq_o    = s_q.flags[BIT_SER_IRQ] && !s_q.mask[BIT_SER_IRQ];

endmodule

// *** csi_slave_checker.sv ***
// checker: port timing of the csi slave top, bound at the file foot
// assumes: strobes one cycle long, ce_i high in checked traffic
`timescale 1ns/1ps
module csi_slave_checker
    import csi_slave_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              ce_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              hs_o,
    input wire logic              hs_oe_o,
    input wire logic              sdo_oe_o,
    input wire logic              irq_o
);
    logic [7:0] dir_q;
    logic [7:0] mask_q;
    logic       wr_ok;
    assign wr_ok = wr_i && ce_i;
    // mirrors of registers only software changes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q  <= RST_DIR;
            mask_q <= RST_MASK;
        end else begin
            dir_q  <= (wr_ok && addr_i == OFF_DIR) ? wdata_i : dir_q;
            mask_q <= (wr_ok && addr_i == OFF_MASK) ? wdata_i : mask_q;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_sdo_dir: assert property ($stable(dir_q) |-> sdo_oe_o == !dir_q[BIT_DOUT_DIR])
        else $error("data out enable differs from direction");
    a_hs_dir: assert property ($stable(dir_q) |-> hs_oe_o == !dir_q[BIT_HS_PIN])
        else $error("handshake enable differs from direction");
    a_hs_level: assert property (wr_ok && addr_i == OFF_PORT
        |-> ##2 hs_o == $past(wdata_i[BIT_HS_PIN], 2)) else $error("handshake level wrong");
    a_irq_masked: assert property ($stable(mask_q) && mask_q[BIT_SER_IRQ] |-> !irq_o)
        else $error("masked request reached irq");
    a_irq_clear: assert property (wr_ok && addr_i == OFF_IRQ && wdata_i[BIT_SER_IRQ]
        |-> ##2 !irq_o) else $error("irq stays after clear");
    a_start_sets: assert property (wr_ok && addr_i == OFF_START && wdata_i[BIT_CH0]
        ##2 rd_i && addr_i == OFF_STATUS |=> rdata_o[BIT_ST_ENABLE])
        else $error("start did not enable");
    a_stop_clears: assert property (wr_ok && addr_i == OFF_STOP && wdata_i[BIT_CH0]
        ##2 rd_i && addr_i == OFF_STATUS |=> !rdata_o[BIT_ST_ENABLE])
        else $error("stop did not disable");
    a_busy_char: assert property ($rose(irq_o) && $stable(mask_q) |-> ##[0:3] hs_o)
        else $error("no busy after character");
    a_read_idle: assert property (!$past(rd_i && ce_i) |-> rdata_o == '0)
        else $error("read data outside answer cycle");
endmodule

bind csi_slave_start_and_handshake csi_slave_checker u_chk (.clk_i, .rst_i, .ce_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .hs_o, .hs_oe_o, .sdo_oe_o, .irq_o);

// *** csi_master_model.sv ***
// model: external serial master, sck idles high, 400 ns bit period
// assumes: busy line pulled high when released by the slave
`timescale 1ns/1ps
module csi_master_model (
    input  wire logic hs_i,
    input  wire logic sdo_i,
    output logic      sck_o,
    output logic      sel_n_o,
    output logic      sdi_o
);
    initial begin
        sck_o   = 1'b1;
        sel_n_o = 1'b1;
        sdi_o   = 1'b0;
    end
    task automatic select(input logic on);
        sel_n_o = !on;
        sdi_o   = ~sdi_o;
        #400;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic lsb,
                        output logic [7:0] rx, output logic ok);
        int n;
        ok = 1'b0;
        // no character until the line reads ready
        for (n = 0; n < 400 && !ok; n++) begin
            #50;
            ok = !hs_i;
        end
        if (!ok)
            return;
        for (n = 0; n < 8; n++) begin
            sck_o = 1'b0;
            sdi_o = lsb ? tx[n] : tx[7-n];
            #200;
            sck_o = 1'b1;
            rx    = lsb ? {sdo_i, rx[7:1]} : {rx[6:0], sdo_i};
            #200;
        end
        sdi_o = ~sdi_o;
        // let the busy level land before polling again
        #500;
    endtask
endmodule

// *** csi_slave_start_and_handshake_bench.sv ***
// bench: register, irq and link scenarios of the csi slave top
// assumes: csi_master_model as far side, checker bound by its own file
`timescale 1ns/1ps
module csi_slave_start_and_handshake_bench;
    import csi_slave_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic       sck, sel_n, sdi, sdo_o, sdo_oe_o, hs_o, hs_oe_o, irq_o;
    logic       rd_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    int         num_errors = 0;
    int         checked = 0;
    always #25 clk_i = ~clk_i;
    csi_slave_start_and_handshake u_dut (.clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .sck_i(sck), .sel_n_i(sel_n), .sdi_i(sdi), .sdo_o, .sdo_oe_o,
        .hs_o, .hs_oe_o, .irq_o);
    csi_master_model u_master (.hs_i(hs_oe_o ? hs_o : 1'b1),
        .sdo_i(sdo_oe_o ? sdo_o : 1'b1), .sck_o(sck), .sel_n_o(sel_n), .sdi_o(sdi));
    task automatic end_sim();
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // --------------------------------------------------------
    // register bus and read monitor
    // --------------------------------------------------------
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    always @(posedge clk_i) rd_d <= rd_i && !rst_i;
    always @(negedge clk_i) begin
        if (rd_d) begin
            check(rdata_o & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    task automatic wait_irq(logic lvl);
        int n;
        for (n = 0; n < 2000 && irq_o !== lvl; n++)
            @(negedge clk_i);
        if (irq_o !== lvl) begin
            num_errors++;
            end_sim();
        end
    endtask
    // --------------------------------------------------------
    // one continuous frame, software serving each character
    // --------------------------------------------------------
    task automatic frame(int len, logic lsb, logic [7:0] msk);
        logic [7:0] tx[4], rxv[4], got;
        logic       ok;
        int         j, k;
        for (j = 0; j < len; j++) begin
            tx[j]  = 8'($urandom);
            rxv[j] = 8'($urandom);
        end
        wr(OFF_MODE, lsb ? 8'h0e : 8'h0c);
        wr(OFF_LEN, 8'(len));
        wr(OFF_MASK, msk);
        wr(OFF_TXDATA, tx[0]);
        wr(OFF_START, 8'h01);
        rd(OFF_STATUS, 8'h01, 8'h41);
        fork
            begin
                u_master.select(1'b1);
                for (j = 0; j < len; j++) begin
                    u_master.xfer(rxv[j], lsb, got, ok);
                    check({7'h0, ok}, 8'h01);
                    check(got, tx[j]);
                end
                u_master.select(1'b0);
            end
            for (k = 0; k < len && !msk[BIT_SER_IRQ]; k++) begin
                wait_irq(1'b1);
                check({7'h0, hs_o}, 8'h01);
                rd(OFF_IRQ, 8'h08, 8'h08);
                wr(OFF_IRQ, 8'h08);
                wait_irq(1'b0);
                rd(OFF_RXDATA, rxv[k]);
                if (k + 1 < len)
                    wr(OFF_TXDATA, tx[k+1]);
                wr(OFF_PORT, 8'h00);
            end
        join
        rd(OFF_STATUS, 8'h00, 8'h41);
        if (msk[BIT_SER_IRQ]) begin
            check({7'h0, irq_o}, 8'h00);
            rd(OFF_IRQ, 8'h08, 8'h08);
            rd(OFF_RXDATA, rxv[0]);
            wr(OFF_MASK, 8'hf7);
            wait_irq(1'b1);
            wr(OFF_IRQ, 8'h08);
            wait_irq(1'b0);
            wr(OFF_PORT, 8'h00);
        end
    endtask
    initial begin
        void'($urandom(13074));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFF_DIR, RST_DIR);
        rd(OFF_PORT, RST_PORT);
        rd(OFF_MASK, RST_MASK);
        rd(OFF_IRQ, 8'h00, 8'h08);
        rd(OFF_MODE, RST_MODE);
        rd(OFF_LEN, RST_LEN);
        rd(4'hf, 8'h00);
        wr(OFF_LEN, 8'h00);
        rd(OFF_LEN, LEN_MIN);
        wr(OFF_LEN, 8'hff);
        rd(OFF_LEN, 8'hff);
        // ready level before the pin turns to output
        wr(OFF_PORT, 8'h00);
        wr(OFF_DIR, 8'hee);
        wr(OFF_START, 8'h00);
        rd(OFF_STATUS, 8'h00, 8'h01);
        frame(3, 1'b0, 8'hf7);
        frame(1, 1'b1, 8'hff);
        wr(OFF_START, 8'h01);
        wr(OFF_STOP, 8'h00);
        rd(OFF_STATUS, 8'h01, 8'h01);
        wr(OFF_STOP, 8'h01);
        rd(OFF_STATUS, 8'h00, 8'h41);
        wr(OFF_PORT, 8'h10);
        wr(OFF_DIR, 8'hff);
        repeat (4) @(posedge clk_i);
        end_sim();
    end
endmodule
